// ===== inc/dds_serial_pkg.sv
package dds_serial_pkg;

  // Word and field widths of the serial port and the datapath.
  localparam int WORD_BITS    = 16;
  localparam int PAYLOAD_BITS = 14;
  localparam int TUNING_BITS  = 28;
  localparam int PHASE_BITS   = 12;
  localparam int DAC_BITS     = 10;
  localparam int COUNT_BITS   = 5;
  localparam int HALF_BITS    = 11;
  localparam int PROD_BITS    = 22;
  localparam int AMP_BITS     = 9;

  // Bit count at which a frame is complete.
  localparam logic [COUNT_BITS-1:0] FULL_COUNT = 5'h10;
  localparam logic [COUNT_BITS-1:0] LAST_COUNT = 5'h0F;
  localparam logic [COUNT_BITS-1:0] COUNT_ONE  = 5'h01;

  // Destination field of a received word.
  localparam int DEST_MSB      = 15;
  localparam int DEST_LSB      = 14;
  localparam int PHASE_SEL_BIT = 13;
  localparam logic [1:0] DEST_CONTROL = 2'h0;
  localparam logic [1:0] DEST_TUNING0 = 2'h1;
  localparam logic [1:0] DEST_TUNING1 = 2'h2;
  localparam logic [1:0] DEST_PHASE   = 2'h3;

  // Bit positions inside the control word.
  localparam int BIT_TWO_WRITE  = 13;
  localparam int BIT_HALF_SEL   = 12;
  localparam int BIT_TW_SEL     = 11;
  localparam int BIT_PH_SEL     = 10;
  localparam int BIT_PIN_SRC    = 9;
  localparam int BIT_RESET      = 8;
  localparam int BIT_CLK_HALT   = 7;
  localparam int BIT_DAC_PD     = 6;
  localparam int BIT_MSB_OE     = 5;
  localparam int BIT_CMP_ROUTE  = 4;
  localparam int BIT_DIV_BYPASS = 3;
  localparam int BIT_RAMP       = 1;

  // Positions used by the waveform shaper.
  localparam int PHASE_TOP_BIT = 16;
  localparam int RAMP_LSB      = 1;
  localparam int AMP_LSB       = 11;

  // Reset values.
  localparam logic [PAYLOAD_BITS-1:0] CONTROL_RESET = 14'h0000;
  localparam logic [TUNING_BITS-1:0]  TUNING_RESET  = 28'h0000000;
  localparam logic [PHASE_BITS-1:0]   PHASE_RESET   = 12'h000;
  localparam logic [DAC_BITS-1:0]     DAC_MIDSCALE  = 10'h200;

  // Pins that come from outside the master clock domain.
  typedef struct packed {
    logic tuning_word_select;
    logic phase_select;
    logic reset;
    logic sleep;
    logic comparator;
  } pin_set_t;

  // State on the serial clock.
  typedef struct packed {
    logic [COUNT_BITS-1:0] count;
    logic [WORD_BITS-1:0]  shift;
    logic [WORD_BITS-1:0]  word;
    logic                  word_ready;
  } link_state_t;

  // State on the master clock.
  typedef struct packed {
    pin_set_t                pin_s1;
    pin_set_t                pin_s2;
    logic                    ready_s1;
    logic                    ready_s2;
    logic                    ready_s3;
    logic [PAYLOAD_BITS-1:0] control;
    logic [TUNING_BITS-1:0]  tuning0;
    logic [TUNING_BITS-1:0]  tuning1;
    logic [PHASE_BITS-1:0]   phase0;
    logic [PHASE_BITS-1:0]   phase1;
    logic                    lsb_loaded0;
    logic                    lsb_loaded1;
    logic [TUNING_BITS-1:0]  acc;
    logic                    msb_prev;
    logic                    div;
    logic [DAC_BITS-1:0]     dac_code;
    logic                    dac_off;
    logic                    sign_out;
    logic                    sign_out_en;
  } core_state_t;

endpackage

// ===== rtl/dds_serial_control_core.sv
`timescale 1ns/10ps
// Overview of operation
// [RQ1] Capture one data bit per falling serial edge.
// [RQ2] Each frame carries exactly one 16-bit word.
// [RQ3] Low frame sync marks a word being loaded.
// [RQ4] Top two bits pick destination; fourteen payload.
// [RQ5] Bit 13 picks phase offset; low twelve load.
// [RQ6] Two-write mode: low half first, then high.
// [RQ7] Single-write mode: half select picks loaded half.
// [RQ8] Two 28-bit tuning words chosen by select.
// [RQ9] Selected phase offset added before waveform lookup.
// [RQ10] Tuning select pin sampled on master clock.
// [RQ11] Host keeps select pins stable near clock edges.
// [RQ12] Phase select pin sampled on master clock.
// [RQ13] Source bit picks pins or control bits.
// [RQ14] Reset bit holds accumulator at zero.
// [RQ15] Reset pin forces accumulator to zero.
// [RQ16] Clock halt freezes accumulator and DAC value.
// [RQ17] DAC power-down bit stops DAC, oscillator runs.
// [RQ18] Sleep pin halts clocks and powers DAC down.
// [RQ19] Output enable bit drives square-wave pin.
// [RQ20] Comparator route picks comparator or accumulator MSB.
// [RQ21] Divide bypass passes MSB, else halves it.
// [RQ22] Waveform mode picks sine shaping or ramp.
// [RQ23] Accumulator adds tuning word, wraps modulo 2^28.
// [RQ24] Commit only after sixteenth bit; drop partial frames.
module dds_serial_control_core (
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  input  wire logic                                clk_en,
  input  wire logic                                serial_clk,
  input  wire logic                                frame_sync_n,
  input  wire logic                                serial_data_in,
  input  wire logic                                tuning_word_select_pin,
  input  wire logic                                phase_select_pin,
  input  wire logic                                reset_pin,
  input  wire logic                                sleep_pin,
  input  wire logic                                comparator_input,
  output logic      [dds_serial_pkg::DAC_BITS-1:0] dac_code,
  output logic                                     dac_powered_down,
  output logic                                     sign_out,
  output logic                                     sign_out_en
);

  dds_serial_pkg::link_state_t link_reg;
  dds_serial_pkg::link_state_t link_next;
  dds_serial_pkg::core_state_t core_reg;
  dds_serial_pkg::core_state_t core_next;
  dds_serial_pkg::pin_set_t    pins_raw;

  logic                                        commit;
  logic [1:0]                                  dest;
  logic [dds_serial_pkg::PAYLOAD_BITS-1:0]     payload;
  logic                                        pin_mode;
  logic                                        fsel;
  logic                                        psel;
  logic                                        rst_active;
  logic                                        halt;
  logic                                        dac_off;
  logic [dds_serial_pkg::TUNING_BITS-1:0]      tuning;
  logic [dds_serial_pkg::PHASE_BITS-1:0]       phase;
  logic [dds_serial_pkg::HALF_BITS-1:0]        half_pos;
  logic [dds_serial_pkg::PROD_BITS-1:0]        prod;
  logic [dds_serial_pkg::AMP_BITS-1:0]         amp;
  logic [dds_serial_pkg::DAC_BITS-1:0]         shaped;
  logic                                        msb;

  assign pins_raw = '{tuning_word_select: tuning_word_select_pin,
                      phase_select:       phase_select_pin,
                      reset:              reset_pin,
                      sleep:              sleep_pin,
                      comparator:         comparator_input};

  // Serial side: shift in MSB first while the frame is open. Bits past the
  // sixteenth are ignored, so an over-long frame still yields one word.
  always_comb
  begin
    link_next = link_reg;
    if (link_reg.count != dds_serial_pkg::FULL_COUNT)
    begin
      link_next.shift = {link_reg.shift[dds_serial_pkg::WORD_BITS-2:0],
                         serial_data_in};                                      // RQ1
      link_next.count = link_reg.count + dds_serial_pkg::COUNT_ONE;
      if (link_reg.count == dds_serial_pkg::LAST_COUNT)
      begin
        link_next.word       = link_next.shift;                               // RQ2
        link_next.word_ready = 1'b1;                                          // RQ24
      end
    end
  end

  // The serial clock may stop between frames, so the frame sync itself ends
  // a frame: while it is high the bit count and the ready flag are held
  // clear, which throws away any partial word.
  always_ff @(negedge serial_clk or posedge frame_sync_n)
  begin
    if (frame_sync_n)
    begin
      link_reg.count      <= '0;                                              // RQ3
      link_reg.word_ready <= 1'b0;                                            // RQ24
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  // Datapath selections from the current control word and synced pins.
  always_comb
  begin
    commit   = core_reg.ready_s2 & ~core_reg.ready_s3;                        // RQ24
    dest     = link_reg.word[dds_serial_pkg::DEST_MSB:dds_serial_pkg::DEST_LSB]; // RQ4
    payload  = link_reg.word[dds_serial_pkg::PAYLOAD_BITS-1:0];
    pin_mode = core_reg.control[dds_serial_pkg::BIT_PIN_SRC];                 // RQ13
    if (pin_mode)
    begin
      fsel       = core_reg.pin_s2.tuning_word_select;                        // RQ10
      psel       = core_reg.pin_s2.phase_select;                              // RQ12
      rst_active = core_reg.pin_s2.reset;                                     // RQ15
      dac_off    = core_reg.pin_s2.sleep;                                     // RQ18
      halt       = core_reg.pin_s2.sleep |
                   core_reg.control[dds_serial_pkg::BIT_CLK_HALT];            // RQ16
    end
    else
    begin
      fsel       = core_reg.control[dds_serial_pkg::BIT_TW_SEL];              // RQ13
      psel       = core_reg.control[dds_serial_pkg::BIT_PH_SEL];
      rst_active = core_reg.control[dds_serial_pkg::BIT_RESET];               // RQ14
      dac_off    = core_reg.control[dds_serial_pkg::BIT_DAC_PD];              // RQ17
      halt       = core_reg.control[dds_serial_pkg::BIT_CLK_HALT];            // RQ16
    end
    tuning = fsel ? core_reg.tuning1 : core_reg.tuning0;                      // RQ8
    phase  = core_reg.acc[dds_serial_pkg::TUNING_BITS-1:dds_serial_pkg::PHASE_TOP_BIT]
           + (psel ? core_reg.phase1 : core_reg.phase0);                      // RQ9
    // A parabola per half cycle stands in for the sine table; it keeps the
    // midscale start and symmetry at a fraction of the area of a ROM.
    half_pos = phase[dds_serial_pkg::HALF_BITS-1:0];
    prod     = dds_serial_pkg::PROD_BITS'(half_pos) * dds_serial_pkg::PROD_BITS'(~half_pos);
    amp      = prod[dds_serial_pkg::AMP_LSB+dds_serial_pkg::AMP_BITS-1:dds_serial_pkg::AMP_LSB];
    if (core_reg.control[dds_serial_pkg::BIT_RAMP])
    begin
      shaped = phase[dds_serial_pkg::PHASE_BITS-1] ?
               ~phase[dds_serial_pkg::DAC_BITS:dds_serial_pkg::RAMP_LSB] :
               phase[dds_serial_pkg::DAC_BITS:dds_serial_pkg::RAMP_LSB];      // RQ22
    end
    else
    begin
      shaped = phase[dds_serial_pkg::PHASE_BITS-1] ?
               dds_serial_pkg::DAC_MIDSCALE - dds_serial_pkg::DAC_BITS'(amp) :
               dds_serial_pkg::DAC_MIDSCALE + dds_serial_pkg::DAC_BITS'(amp); // RQ22
    end
    msb = core_reg.acc[dds_serial_pkg::TUNING_BITS-1];
  end

  // Master clock side: synchronisers, register loads, accumulator, outputs.
  always_comb
  begin
    core_next = core_reg;
    if (clk_en)
    begin
      core_next.pin_s1   = pins_raw;
      core_next.pin_s2   = core_reg.pin_s1;
      core_next.ready_s1 = link_reg.word_ready;
      core_next.ready_s2 = core_reg.ready_s1;
      core_next.ready_s3 = core_reg.ready_s2;
      // The word register is stable from the ready flag until the next
      // frame completes, so it is safe to read after the flag is synced.
      if (commit)
      begin
        case (dest)
          dds_serial_pkg::DEST_CONTROL:
          begin
            core_next.control     = payload;
            core_next.lsb_loaded0 = 1'b0;
            core_next.lsb_loaded1 = 1'b0;
          end
          dds_serial_pkg::DEST_TUNING0:
          begin
            if (core_reg.control[dds_serial_pkg::BIT_TWO_WRITE])
            begin
              if (core_reg.lsb_loaded0)
                core_next.tuning0[dds_serial_pkg::TUNING_BITS-1:dds_serial_pkg::PAYLOAD_BITS]
                  = payload;                                                  // RQ6
              else
                core_next.tuning0[dds_serial_pkg::PAYLOAD_BITS-1:0] = payload; // RQ6
              core_next.lsb_loaded0 = ~core_reg.lsb_loaded0;
            end
            else if (core_reg.control[dds_serial_pkg::BIT_HALF_SEL])
              core_next.tuning0[dds_serial_pkg::TUNING_BITS-1:dds_serial_pkg::PAYLOAD_BITS]
                = payload;                                                    // RQ7
            else
              core_next.tuning0[dds_serial_pkg::PAYLOAD_BITS-1:0] = payload;  // RQ7
          end
          dds_serial_pkg::DEST_TUNING1:
          begin
            if (core_reg.control[dds_serial_pkg::BIT_TWO_WRITE])
            begin
              if (core_reg.lsb_loaded1)
                core_next.tuning1[dds_serial_pkg::TUNING_BITS-1:dds_serial_pkg::PAYLOAD_BITS]
                  = payload;                                                  // RQ6
              else
                core_next.tuning1[dds_serial_pkg::PAYLOAD_BITS-1:0] = payload; // RQ6
              core_next.lsb_loaded1 = ~core_reg.lsb_loaded1;
            end
            else if (core_reg.control[dds_serial_pkg::BIT_HALF_SEL])
              core_next.tuning1[dds_serial_pkg::TUNING_BITS-1:dds_serial_pkg::PAYLOAD_BITS]
                = payload;                                                    // RQ7
            else
              core_next.tuning1[dds_serial_pkg::PAYLOAD_BITS-1:0] = payload;  // RQ7
          end
          dds_serial_pkg::DEST_PHASE:
          begin
            if (payload[dds_serial_pkg::PHASE_SEL_BIT])
              core_next.phase1 = payload[dds_serial_pkg::PHASE_BITS-1:0];     // RQ5
            else
              core_next.phase0 = payload[dds_serial_pkg::PHASE_BITS-1:0];     // RQ5
          end
          default:
          begin
            core_next.control = core_reg.control;
          end
        endcase
      end
      // Reset wins over halt so a halted core can still be parked at zero.
      if (rst_active)
        core_next.acc = dds_serial_pkg::TUNING_RESET;                         // RQ14
      else if (!halt)
        core_next.acc = core_reg.acc + tuning;                                // RQ23
      if (!halt)
      begin
        core_next.dac_code = shaped;                                          // RQ16
        core_next.msb_prev = msb;
        if (msb && !core_reg.msb_prev)
          core_next.div = ~core_reg.div;                                      // RQ21
      end
      core_next.dac_off     = dac_off;                                        // RQ17
      core_next.sign_out_en = core_reg.control[dds_serial_pkg::BIT_MSB_OE];   // RQ19
      if (core_reg.control[dds_serial_pkg::BIT_CMP_ROUTE])
        core_next.sign_out = core_reg.pin_s2.comparator;                      // RQ20
      else if (core_reg.control[dds_serial_pkg::BIT_DIV_BYPASS])
        core_next.sign_out = msb;                                             // RQ21
      else
        core_next.sign_out = core_reg.div;                                    // RQ21
    end
  end

  // Control state resets; the data registers reset too so the output is
  // midscale and quiet until software programs the core.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_reg             <= '0;
      core_reg.control     <= dds_serial_pkg::CONTROL_RESET;
      core_reg.tuning0     <= dds_serial_pkg::TUNING_RESET;
      core_reg.tuning1     <= dds_serial_pkg::TUNING_RESET;
      core_reg.phase0      <= dds_serial_pkg::PHASE_RESET;
      core_reg.phase1      <= dds_serial_pkg::PHASE_RESET;
      core_reg.dac_code    <= dds_serial_pkg::DAC_MIDSCALE;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign dac_code         = core_reg.dac_code;
  assign dac_powered_down = core_reg.dac_off;
  assign sign_out         = core_reg.sign_out;
  assign sign_out_en      = core_reg.sign_out_en;

endmodule

// ===== test/dds_serial_control_core_props.sv
`timescale 1ns/10ps
// Port-level checks on the core; its internal registers are not visible from here.
module dds_serial_control_core_props (
  input wire logic                                clk,
  input wire logic                                sys_rst,
  input wire logic                                clk_en,
  input wire logic                                frame_sync_n,
  input wire logic                                sleep_pin,
  input wire logic [dds_serial_pkg::DAC_BITS-1:0] dac_code,
  input wire logic                                dac_powered_down,
  input wire logic                                sign_out,
  input wire logic                                sign_out_en
);
  logic [4:0] since_frame_reg;
  logic [2:0] since_sleep_reg;
  logic       sleep_prev_reg;
  logic       no_frame_reg;

  // Ages saturate, so a long idle stretch never wraps back into a cause window.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      since_frame_reg <= 5'h1F;
      since_sleep_reg <= 3'h7;
      sleep_prev_reg  <= sleep_pin;
      no_frame_reg    <= 1'b1;
    end
    else
    begin
      sleep_prev_reg <= sleep_pin;
      if (!frame_sync_n)
      begin
        since_frame_reg <= 5'h00;
        no_frame_reg    <= 1'b0;
      end
      else if (since_frame_reg != 5'h1F)
        since_frame_reg <= since_frame_reg + 5'h01;
      if (sleep_pin != sleep_prev_reg)
        since_sleep_reg <= 3'h0;
      else if (since_sleep_reg != 3'h7)
        since_sleep_reg <= since_sleep_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  reset_midscale_a: assert property (
    $fell(sys_rst) |-> dac_code == 10'h200 && !dac_powered_down)
    else $error("dac not at midscale after reset");
  reset_quiet_a: assert property (
    $fell(sys_rst) |-> !sign_out_en && !sign_out)
    else $error("square-wave pin active after reset");
  idle_midscale_a: assert property (
    no_frame_reg |-> dac_code == 10'h200 && !dac_powered_down)
    else $error("output moved with zero tuning words");
  dac_frozen_a: assert property (
    !clk_en |=> $stable(dac_code))
    else $error("dac code moved while clock disabled");
  sign_frozen_a: assert property (
    !clk_en |=> $stable(sign_out) && $stable(sign_out_en))
    else $error("square-wave pin moved while clock disabled");
  pd_frozen_a: assert property (
    !clk_en ##1 !clk_en |=> $stable(dac_powered_down))
    else $error("power-down moved while clock disabled");
  en_needs_frame_a: assert property (
    $changed(sign_out_en) |-> since_frame_reg < 5'h14)
    else $error("output enable changed without a frame");
  pd_needs_cause_a: assert property (
    $changed(dac_powered_down) |-> since_frame_reg < 5'h14 || since_sleep_reg < 3'h6)
    else $error("power-down changed without frame or sleep change");

  cover property ($rose(sign_out_en));
  cover property ($rose(dac_powered_down));
  cover property (!clk_en ##1 !clk_en);
endmodule

bind dds_serial_control_core dds_serial_control_core_props u_props (
  .clk              (clk),
  .sys_rst          (sys_rst),
  .clk_en           (clk_en),
  .frame_sync_n     (frame_sync_n),
  .sleep_pin        (sleep_pin),
  .dac_code         (dac_code),
  .dac_powered_down (dac_powered_down),
  .sign_out         (sign_out),
  .sign_out_en      (sign_out_en)
);

// ===== test/dds_host_model.sv
`timescale 1ns/10ps
// Host side of the serial port; its clock idles high and stands still between frames.
module dds_host_model (
  output logic serial_clk,
  output logic frame_sync_n,
  output logic serial_data_in
);
  // The port has no reset of its own, so a short frame sync pulse with no clock edge
  // gives its bit count a known empty start before the first frame.
  initial
  begin
    serial_clk     = 1'b1;
    frame_sync_n   = 1'b0;
    serial_data_in = 1'b0;
    #1 frame_sync_n = 1'b1;
  end

  // Shifts n bits MSB first; each bit settles half a period before its capturing fall.
  task automatic send_bits(input logic [15:0] w, input int n);
    #7 frame_sync_n = 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      serial_data_in = w[i];
      #24 serial_clk = 1'b0;
      #24 serial_clk = 1'b1;
    end
    #24 frame_sync_n = 1'b1;
    serial_data_in = ~serial_data_in; // A released line must not look like held data.
    #100;
  endtask
endmodule

// ===== test/tb_dds_serial_control_core.sv
`timescale 1ns/10ps
module tb_dds_serial_control_core;
  logic       clk;
  logic       sys_rst;
  logic       clk_en;
  logic       tuning_word_select_pin;
  logic       phase_select_pin;
  logic       reset_pin;
  logic       sleep_pin;
  logic       comparator_input;
  wire logic  serial_clk;
  wire logic  frame_sync_n;
  wire logic  serial_data_in;
  logic [dds_serial_pkg::DAC_BITS-1:0] dac_code;
  logic       dac_powered_down;
  logic       sign_out;
  logic       sign_out_en;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  int         ctrl = 0;
  int         r;
  int         tw [2] = '{0, 0};
  int         ph [2] = '{0, 0};
  bit         pend [2] = '{0, 0};
  logic [9:0] s [$];
  logic       q [$];

  dds_host_model u_host (
    .serial_clk     (serial_clk),
    .frame_sync_n   (frame_sync_n),
    .serial_data_in (serial_data_in)
  );

  dds_serial_control_core u_dut (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .clk_en                 (clk_en),
    .serial_clk             (serial_clk),
    .frame_sync_n           (frame_sync_n),
    .serial_data_in         (serial_data_in),
    .tuning_word_select_pin (tuning_word_select_pin),
    .phase_select_pin       (phase_select_pin),
    .reset_pin              (reset_pin),
    .sleep_pin              (sleep_pin),
    .comparator_input       (comparator_input),
    .dac_code               (dac_code),
    .dac_powered_down       (dac_powered_down),
    .sign_out               (sign_out),
    .sign_out_en            (sign_out_en)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // The ceiling is over ten times the expected run, so only a hang reaches it.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ramp output of a 12-bit phase: rising triangle, mirrored in the upper half.
  function automatic logic [9:0] ramp(input int p);
    logic [11:0] v;
    v = p[11:0];
    return v[11] ? ~v[10:1] : v[10:1];
  endfunction

  // Sends one word and mirrors its effect in the reference registers.
  task automatic send(input logic [15:0] w);
    int i;
    i = (w[15:14] == 2'h2) ? 1 : 0;
    u_host.send_bits(w, 16);
    case (w[15:14])
      2'h0:
      begin
        ctrl = w[13:0];
        pend = '{0, 0};
      end
      2'h3: ph[w[13]] = w[11:0];
      default:
      begin
        if (ctrl[13] ? pend[i] : ctrl[12])
          tw[i] = (tw[i] & 28'h0003FFF) | (w[13:0] << 14);
        else
          tw[i] = (tw[i] & 28'hFFFC000) | w[13:0];
        if (ctrl[13])
          pend[i] = !pend[i];
      end
    endcase
    repeat (6) @(negedge clk);
  endtask

  // Takes nine consecutive settled samples of dac_code and sign_out.
  task automatic grab();
    s.delete();
    q.delete();
    repeat (9)
    begin
      @(negedge clk);
      s.push_back(dac_code);
      q.push_back(sign_out);
    end
  endtask

  // The start phase is unknown, so the model is aligned once and then must track.
  task automatic pat(input int step, input int off);
    int k;
    k = 0;
    grab();
    while (k < 4096 && ramp(k * step + off) !== s[0])
      k++;
    foreach (s[j])
      chk("dac_code", ramp((k + j) * step + off), s[j]);
  endtask

  task automatic edges(input int n);
    int t;
    t = 0;
    grab();
    for (int j = 0; j < 8; j++)
      t += (q[j] !== q[j + 1]);
    chk("sign_edges", n, t);
  endtask

  // Pins change only at falling edges, well clear of the sampling edge.
  initial
  begin
    {sys_rst, clk_en, tuning_word_select_pin, phase_select_pin} = 4'hC;
    {reset_pin, sleep_pin, comparator_input} = 3'h0;
    r = $urandom(76798);
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    sleep_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk("pd_bitmode", 16'h0000, dac_powered_down);
    chk("dac_idle", 16'h0200, dac_code);
    sleep_pin = 1'b0;
    for (int n = 0; n < 4; n++)
    begin
      r = $urandom();
      send({2'h3, n[0], 1'b0, r[11:0]});
      send({5'h00, n[0], 10'h102});
      pat(0, ph[n % 2]);
    end
    u_host.send_bits(16'hEABC, 10);
    repeat (6) @(negedge clk);
    pat(0, ph[1]);
    send(16'hC000);
    send(16'h0100);
    chk("dac_sine_zero", 16'h0200, dac_code);
    send(16'h2102);
    send(16'h4000);
    send(16'h6000);
    send(16'h202A);
    pat(tw[0] >> 16, ph[0]);
    edges(8);
    send(16'h2022);
    edges(4);
    send(16'h1000);
    send(16'h9000);
    send(16'h0842);
    pat(tw[1] >> 16, ph[0]);
    chk("pd_bit", 16'h0001, dac_powered_down);
    clk_en = 1'b0;
    repeat (4) @(negedge clk);
    clk_en = 1'b1;
    // Park the output at a known code first, so the halted value is predictable.
    send(16'h0102);
    send(16'h0182);
    send(16'h0882);
    pat(0, ph[0]);
    send(16'h0202);
    tuning_word_select_pin = 1'b1;
    repeat (5) @(negedge clk);
    pat(tw[1] >> 16, ph[0]);
    tuning_word_select_pin = 1'b0;
    repeat (5) @(negedge clk);
    pat(tw[0] >> 16, ph[0]);
    {reset_pin, phase_select_pin} = 2'h3;
    repeat (5) @(negedge clk);
    pat(0, ph[1]);
    {reset_pin, sleep_pin} = 2'h1;
    repeat (5) @(negedge clk);
    pat(0, ph[1]);
    chk("pd_sleep", 16'h0001, dac_powered_down);
    sleep_pin = 1'b0;
    send(16'h0030);
    for (int n = 0; n < 6; n++)
    begin
      comparator_input = 1'($urandom());
      repeat (5) @(negedge clk);
      chk("sign_cmp", comparator_input, sign_out);
    end
    chk("sign_en_on", 16'h0001, sign_out_en);
    send(16'h0000);
    chk("sign_en_off", 16'h0000, sign_out_en);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk("dac_rerst", 16'h0200, dac_code);
    finish_test();
  end
endmodule
